// ==== logic/asd_pkg.sv ====
// Constants and types shared by the address space decoder.
package asd_pkg;

   // ****************************************
   // Register file space
   // ****************************************
   localparam int RF_ADDR_W = 12;
   localparam int RF_BYTES = 4096;
   localparam logic [11:0] CTL_BASE = 12'hf00;
   localparam logic [11:0] CTL_LAST = 12'hfff;
   localparam logic [11:0] RAM_BASE = 12'h000;
   localparam int RAM_BYTES_DEF = 256;
   localparam logic [7:0] UNDEF_DATA = 8'h00;

   // ****************************************
   // Program memory space
   // ****************************************
   localparam int PM_ADDR_W = 16;
   localparam int FLASH_BYTES_DEF = 8192;
   localparam int FLASH_BYTES_MIN = 1024;
   localparam int FLASH_BYTES_MAX = 12288;
   localparam logic [7:0] UNIMPL_DATA = 8'hff;
   localparam logic [15:0] OPT_LAST = 16'h0001;
   localparam logic [15:0] RST_VEC_LAST = 16'h0003;
   localparam logic [15:0] INT_VEC_LAST = 16'h003d;

   // ****************************************
   // Information area overlay
   // ****************************************
   localparam int INFO_EN_BIT = 7;
   localparam logic [15:0] INFO_BASE = 16'hfe00;
   localparam logic [15:0] INFO_LAST = 16'hfe7f;
   localparam logic [6:0] INFO_OPT_LAST = 7'h3f;
   localparam logic [6:0] PART_FIRST = 7'h40;
   localparam logic [6:0] PART_LAST = 7'h53;
   localparam int PART_CHARS = 20;
   localparam logic [6:0] CAL_FIRST = 7'h60;
   localparam logic [7:0] PART_PAD = 8'h46;
   localparam logic [7:0] RSVD_DATA = 8'hff;

   // ****************************************
   // Reset values and types
   // ****************************************
   localparam logic [7:0] DATA_RST = 8'h00;

   typedef enum {
      SRC_NONE,
      SRC_RAM,
      SRC_CTL,
      SRC_FLASH,
      SRC_INFO,
      SRC_CONST
   } asd_src_t;

   typedef enum logic [2:0] {
      REG_NONE,
      REG_OPTION,
      REG_RESET_VEC,
      REG_INT_VEC,
      REG_CODE
   } asd_region_t;

endpackage

// ==== logic/asd_address_space_decoder.sv ====
// Address decoder between the processor core and its memories and control page.
//
// Contract
// (R1) Register file space spans 4096 bytes; reads source and writes destination operands.
// (R2) Register addresses F00H to FFFH go to the control register page.
// (R3) Reads of unassigned control page addresses may return any value.
// (R4) Software should not write unassigned control page addresses.
// (R5) On-chip RAM starts at register address 000H, up to 256 bytes.
// (R6) Between RAM and control page, reads are undefined and writes ignored.
// (R7) Program space is 64KB; flash of 1KB to 12KB fills its bottom.
// (R8) Program reads beyond flash return FFH; writes there do nothing.
// (R9) Option bits, reset vector, interrupt vectors, then code, at fixed addresses.
// (R10) Data memory space is unused; nothing answers data memory accesses.
// (R11) Information area access is enabled by bit 7 of flash page select.
// (R12) When enabled, program reads FE00H to FE7FH return information area data.
// (R13) The information area is read only; writes never change it.
// (R14) Info layout: option bits, 20-char padded part name, reserved, calibration.
// (R15) With the overlay disabled, FE00H to FE7FH decode as normal program memory.
`timescale 1ns/1ps
module asd_address_space_decoder #(
   parameter int RAM_BYTES = asd_pkg::RAM_BYTES_DEF,
   parameter int FLASH_BYTES = asd_pkg::FLASH_BYTES_DEF,
   parameter int PART_LEN = 7,
   // Arbitrary neutral part name, right-aligned in the vector, PART_LEN chars used.
   parameter logic [8*asd_pkg::PART_CHARS-1:0] PART_ID = "ASDDEMO"
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [asd_pkg::RF_ADDR_W-1:0] rfAddr,
   input wire logic rfRd,
   input wire logic rfWr,
   input wire logic [7:0] rfWdata,
   output logic [7:0] rfRdata,
   output logic rfRdValid,
   input wire logic [asd_pkg::PM_ADDR_W-1:0] pmAddr,
   input wire logic pmRd,
   input wire logic pmWr,
   input wire logic [7:0] pmWdata,
   output logic [7:0] pmRdata,
   output logic pmRdValid,
   output asd_pkg::asd_region_t pmRegion,
   input wire logic dmRd,
   input wire logic dmWr,
   output logic dmDropped,
   output logic ramSel,
   output logic ramWe,
   output logic [7:0] ramAddr,
   output logic [7:0] ramWdata,
   input wire logic [7:0] ramRdata,
   output logic ctlSel,
   output logic ctlWe,
   output logic [7:0] ctlAddr,
   output logic [7:0] ctlWdata,
   input wire logic [7:0] ctlRdata,
   output logic flashRe,
   output logic flashWe,
   output logic [asd_pkg::PM_ADDR_W-1:0] flashAddr,
   output logic [7:0] flashWdata,
   input wire logic [7:0] flashRdata,
   output logic infoRe,
   output logic [6:0] infoAddr,
   input wire logic [7:0] infoRdata,
   input wire logic [7:0] pageSel
);

   // ****************************************
   // Decode limits
   // ****************************************
   localparam logic [12:0] RAM_LIMIT = 13'(RAM_BYTES);
   localparam logic [16:0] FLASH_LIMIT = 17'(FLASH_BYTES);

   // ****************************************
   // Register file strobe stage
   // ****************************************
   logic ramSel_reg, ramSel_next;
   logic ramWe_reg, ramWe_next;
   logic [7:0] ramAddr_reg, ramAddr_next;
   logic ctlSel_reg, ctlSel_next;
   logic ctlWe_reg, ctlWe_next;
   logic [7:0] ctlAddr_reg, ctlAddr_next;
   logic [7:0] rfWdata_reg, rfWdata_next;
   asd_pkg::asd_src_t rfSrc_reg, rfSrc_next;

   // A read and a write in one cycle is treated as a read, so no store is half done.
   always_comb begin
      ramSel_next = 1'b0;
      ramWe_next = 1'b0;
      ramAddr_next = ramAddr_reg;
      ctlSel_next = 1'b0;
      ctlWe_next = 1'b0;
      ctlAddr_next = ctlAddr_reg;
      rfWdata_next = rfWdata_reg;
      rfSrc_next = asd_pkg::SRC_NONE;
      if (rfRd || rfWr) begin // (R1)
         rfWdata_next = rfWdata;
         if (rfAddr >= asd_pkg::CTL_BASE && rfAddr <= asd_pkg::CTL_LAST) begin // (R2)
            // The page itself answers unassigned offsets; its value is not ours to define.
            ctlSel_next = 1'b1; // (R3)
            ctlWe_next = rfWr && !rfRd;
            ctlAddr_next = rfAddr[7:0];
            if (rfRd) begin
               rfSrc_next = asd_pkg::SRC_CTL;
            end
         end else if ({1'b0, rfAddr} < RAM_LIMIT && rfAddr >= asd_pkg::RAM_BASE) begin // (R5)
            ramSel_next = 1'b1;
            ramWe_next = rfWr && !rfRd;
            ramAddr_next = rfAddr[7:0];
            if (rfRd) begin
               rfSrc_next = asd_pkg::SRC_RAM;
            end
         end else if (rfRd) begin
            rfSrc_next = asd_pkg::SRC_CONST; // (R6)
         end
      end
   end

   // Strobes to RAM and control page are registered so no glitch reaches them.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ramSel_reg <= 1'b0;
         ramWe_reg <= 1'b0;
         ramAddr_reg <= asd_pkg::DATA_RST;
         ctlSel_reg <= 1'b0;
         ctlWe_reg <= 1'b0;
         ctlAddr_reg <= asd_pkg::DATA_RST;
         rfWdata_reg <= asd_pkg::DATA_RST;
         rfSrc_reg <= asd_pkg::SRC_NONE;
      end else begin
         ramSel_reg <= ramSel_next;
         ramWe_reg <= ramWe_next;
         ramAddr_reg <= ramAddr_next;
         ctlSel_reg <= ctlSel_next;
         ctlWe_reg <= ctlWe_next;
         ctlAddr_reg <= ctlAddr_next;
         rfWdata_reg <= rfWdata_next;
         rfSrc_reg <= rfSrc_next;
      end
   end

   // ****************************************
   // Register file read return stage
   // ****************************************
   logic [7:0] rfRdata_reg, rfRdata_next;
   logic rfRdValid_reg, rfRdValid_next;

   // The gap between RAM and control page reads a fixed value; any value would be legal.
   always_comb begin
      rfRdata_next = rfRdata_reg;
      rfRdValid_next = 1'b1;
      case (rfSrc_reg)
         asd_pkg::SRC_RAM: rfRdata_next = ramRdata;
         asd_pkg::SRC_CTL: rfRdata_next = ctlRdata;
         asd_pkg::SRC_CONST: rfRdata_next = asd_pkg::UNDEF_DATA; // (R6)
         default: rfRdValid_next = 1'b0;
      endcase
   end

   // Read data is held until the next read so the core may sample late.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rfRdata_reg <= asd_pkg::DATA_RST;
         rfRdValid_reg <= 1'b0;
      end else begin
         rfRdata_reg <= rfRdata_next;
         rfRdValid_reg <= rfRdValid_next;
      end
   end

   // ****************************************
   // Program memory strobe stage
   // ****************************************
   logic flashRe_reg, flashRe_next;
   logic flashWe_reg, flashWe_next;
   logic [15:0] flashAddr_reg, flashAddr_next;
   logic [7:0] flashWdata_reg, flashWdata_next;
   logic infoRe_reg, infoRe_next;
   logic [6:0] infoAddr_reg, infoAddr_next;
   logic [7:0] pmConst_reg, pmConst_next;
   asd_pkg::asd_src_t pmSrc_reg, pmSrc_next;
   asd_pkg::asd_region_t pmRegion_reg, pmRegion_next;
   logic dmDropped_reg, dmDropped_next;

   // Flash and overlay decode; the overlay only ever steers reads.
   always_comb begin
      logic infoHit;
      logic flashHit;
      logic [6:0] off;
      logic [6:0] chr;
      infoHit = 1'b0;
      flashHit = 1'b0;
      off = pmAddr[6:0];
      chr = 7'(off - asd_pkg::PART_FIRST);
      flashRe_next = 1'b0;
      flashWe_next = 1'b0;
      flashAddr_next = flashAddr_reg;
      flashWdata_next = flashWdata_reg;
      infoRe_next = 1'b0;
      infoAddr_next = infoAddr_reg;
      pmConst_next = pmConst_reg;
      pmSrc_next = asd_pkg::SRC_NONE;
      pmRegion_next = asd_pkg::REG_NONE;
      // Nothing is wired to the data space; an access there is only reported.
      dmDropped_next = dmRd || dmWr; // (R10)
      infoHit = pageSel[asd_pkg::INFO_EN_BIT] && pmAddr >= asd_pkg::INFO_BASE && // (R11)
                pmAddr <= asd_pkg::INFO_LAST;
      flashHit = {1'b0, pmAddr} < FLASH_LIMIT; // (R7)
      if (pmRd || pmWr) begin
         if (!flashHit) begin
            pmRegion_next = asd_pkg::REG_NONE;
         end else if (pmAddr <= asd_pkg::OPT_LAST) begin // (R9)
            pmRegion_next = asd_pkg::REG_OPTION;
         end else if (pmAddr <= asd_pkg::RST_VEC_LAST) begin // (R9)
            pmRegion_next = asd_pkg::REG_RESET_VEC;
         end else if (pmAddr <= asd_pkg::INT_VEC_LAST) begin // (R9)
            pmRegion_next = asd_pkg::REG_INT_VEC;
         end else begin
            pmRegion_next = asd_pkg::REG_CODE; // (R9)
         end
      end
      if (pmRd) begin
         if (infoHit) begin // (R12)
            if (off <= asd_pkg::INFO_OPT_LAST || off >= asd_pkg::CAL_FIRST) begin // (R14)
               infoRe_next = 1'b1;
               infoAddr_next = off;
               pmSrc_next = asd_pkg::SRC_INFO;
            end else if (off >= asd_pkg::PART_FIRST && off <= asd_pkg::PART_LAST) begin
               // Name is left-aligned; unused trailing characters read as padding.
               pmSrc_next = asd_pkg::SRC_CONST;
               if (int'(chr) < PART_LEN) begin // (R14)
                  pmConst_next = PART_ID[8*(PART_LEN-1-int'(chr)) +: 8];
               end else begin
                  pmConst_next = asd_pkg::PART_PAD;
               end
            end else begin
               pmSrc_next = asd_pkg::SRC_CONST;
               pmConst_next = asd_pkg::RSVD_DATA;
            end
         end else if (flashHit) begin // (R15)
            flashRe_next = 1'b1;
            flashAddr_next = pmAddr;
            pmSrc_next = asd_pkg::SRC_FLASH;
         end else begin
            pmSrc_next = asd_pkg::SRC_CONST;
            pmConst_next = asd_pkg::UNIMPL_DATA; // (R8)
         end
      end else if (pmWr && flashHit) begin
         // Writes never reach the info store; above flash they vanish.
         flashWe_next = 1'b1; // (R13)
         flashAddr_next = pmAddr;
         flashWdata_next = pmWdata;
      end
   end

   // Flash and info strobes leave from flip-flops, one cycle after the request.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flashRe_reg <= 1'b0;
         flashWe_reg <= 1'b0;
         flashAddr_reg <= 16'h0000;
         flashWdata_reg <= asd_pkg::DATA_RST;
         infoRe_reg <= 1'b0;
         infoAddr_reg <= 7'h00;
         pmConst_reg <= asd_pkg::DATA_RST;
         pmSrc_reg <= asd_pkg::SRC_NONE;
         pmRegion_reg <= asd_pkg::REG_NONE;
         dmDropped_reg <= 1'b0;
      end else begin
         flashRe_reg <= flashRe_next;
         flashWe_reg <= flashWe_next;
         flashAddr_reg <= flashAddr_next;
         flashWdata_reg <= flashWdata_next;
         infoRe_reg <= infoRe_next;
         infoAddr_reg <= infoAddr_next;
         pmConst_reg <= pmConst_next;
         pmSrc_reg <= pmSrc_next;
         pmRegion_reg <= pmRegion_next;
         dmDropped_reg <= dmDropped_next;
      end
   end

   // ****************************************
   // Program memory read return stage
   // ****************************************
   logic [7:0] pmRdata_reg, pmRdata_next;
   logic pmRdValid_reg, pmRdValid_next;

   // Return data picks the source chosen a cycle earlier.
   always_comb begin
      pmRdata_next = pmRdata_reg;
      pmRdValid_next = 1'b1;
      case (pmSrc_reg)
         asd_pkg::SRC_FLASH: pmRdata_next = flashRdata;
         asd_pkg::SRC_INFO: pmRdata_next = infoRdata; // (R12)
         asd_pkg::SRC_CONST: pmRdata_next = pmConst_reg;
         default: pmRdValid_next = 1'b0;
      endcase
   end

   // Read data is held until the next program read.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pmRdata_reg <= asd_pkg::DATA_RST;
         pmRdValid_reg <= 1'b0;
      end else begin
         pmRdata_reg <= pmRdata_next;
         pmRdValid_reg <= pmRdValid_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rfRdata = rfRdata_reg;
   assign rfRdValid = rfRdValid_reg;
   assign ramSel = ramSel_reg;
   assign ramWe = ramWe_reg;
   assign ramAddr = ramAddr_reg;
   assign ramWdata = rfWdata_reg;
   assign ctlSel = ctlSel_reg;
   assign ctlWe = ctlWe_reg;
   assign ctlAddr = ctlAddr_reg;
   assign ctlWdata = rfWdata_reg;
   assign pmRdata = pmRdata_reg;
   assign pmRdValid = pmRdValid_reg;
   assign pmRegion = pmRegion_reg;
   assign dmDropped = dmDropped_reg;
   assign flashRe = flashRe_reg;
   assign flashWe = flashWe_reg;
   assign flashAddr = flashAddr_reg;
   assign flashWdata = flashWdata_reg;
   assign infoRe = infoRe_reg;
   assign infoAddr = infoAddr_reg;

endmodule

// ==== testbench/asd_checker_sva.sv ====
// Concurrent checks on the ports of the address space decoder.
`timescale 1ns/1ps
module asd_checker_sva #(
   parameter int RAM_BYTES = 256,
   parameter int FLASH_BYTES = 8192
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [11:0] rfAddr,
   input wire logic rfRd,
   input wire logic rfWr,
   input wire logic [7:0] rfWdata,
   input wire logic rfRdValid,
   input wire logic [15:0] pmAddr,
   input wire logic pmRd,
   input wire logic pmWr,
   input wire logic [7:0] pmWdata,
   input wire logic [7:0] pmRdata,
   input wire logic pmRdValid,
   input wire asd_pkg::asd_region_t pmRegion,
   input wire logic dmRd,
   input wire logic dmWr,
   input wire logic dmDropped,
   input wire logic ramSel,
   input wire logic ramWe,
   input wire logic [7:0] ramAddr,
   input wire logic ctlSel,
   input wire logic ctlWe,
   input wire logic [7:0] ctlAddr,
   input wire logic [7:0] ctlWdata,
   input wire logic flashRe,
   input wire logic flashWe,
   input wire logic [15:0] flashAddr,
   input wire logic [7:0] flashWdata,
   input wire logic infoRe,
   input wire logic [6:0] infoAddr,
   input wire logic [7:0] pageSel
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // ****************************************
   // Helper decode
   // ****************************************
   // Overlay window hit, and the part of it that is served by the info store.
   logic infoHit;
   logic infoStore;
   assign infoHit = pageSel[7] && (pmAddr[15:7] == 9'h1fc);
   assign infoStore = infoHit && (pmAddr[6:5] != 2'b10);

   // ****************************************
   // Assertions
   // ****************************************
   ram_read_a: assert property (rfRd && rfAddr < RAM_BYTES |=> ramSel && !ramWe && !ctlSel
      && ramAddr == $past(rfAddr[7:0])) else $error("RAM read not strobed");
   ctl_write_a: assert property (rfWr && !rfRd && rfAddr >= 12'hf00 |=> ctlSel && ctlWe
      && ctlAddr == $past(rfAddr[7:0]) && ctlWdata == $past(rfWdata)) else $error("ctl write lost");
   gap_quiet_a: assert property (rfWr && rfAddr >= RAM_BYTES && rfAddr < 12'hf00
      |=> !ramSel && !ctlSel) else $error("gap write reached a memory");
   rf_valid_a: assert property (rfRd |-> ##2 rfRdValid) else $error("rf read not answered");
   flash_read_a: assert property (pmRd && pmAddr < FLASH_BYTES |=> flashRe
      && flashAddr == $past(pmAddr)) else $error("flash read not strobed");
   above_flash_a: assert property (pmRd && pmAddr >= FLASH_BYTES && !infoHit
      |=> !flashRe && !infoRe ##1 pmRdValid && pmRdata == 8'hff) else $error("FF not returned");
   // A read and a write together count as a read, which may rightly strobe the info store.
   write_ignored_a: assert property (pmWr && !pmRd && pmAddr >= FLASH_BYTES |=> !flashWe
      && !infoRe) else $error("write beyond flash acted");
   flash_write_a: assert property (pmWr && !pmRd && pmAddr < FLASH_BYTES |=> flashWe
      && flashAddr == $past(pmAddr) && flashWdata == $past(pmWdata))
      else $error("flash write lost");
   overlay_read_a: assert property (pmRd && infoStore |=> infoRe && !flashRe
      && infoAddr == $past(pmAddr[6:0])) else $error("overlay not served");
   dm_drop_a: assert property ((dmRd || dmWr) |=> dmDropped) else $error("dm access not dropped");
   region_opt_a: assert property (pmRd && pmAddr <= 16'h0001 |=> pmRegion == asd_pkg::REG_OPTION)
      else $error("option region wrong");

   // ****************************************
   // Coverage
   // ****************************************
   ctl_write_c: cover property (ctlSel && ctlWe);
   overlay_c: cover property (infoRe);
   above_flash_c: cover property (pmRd && pmAddr >= FLASH_BYTES);
endmodule

// ==== testbench/asd_mem_model.sv ====
// Behavioural memories and control page behind the decoder.
`timescale 1ns/1ps
module asd_mem_model (
   input wire logic clock,
   input wire logic ramSel,
   input wire logic ramWe,
   input wire logic [7:0] ramAddr,
   input wire logic [7:0] ramWdata,
   output logic [7:0] ramRdata,
   input wire logic ctlSel,
   input wire logic ctlWe,
   input wire logic [7:0] ctlAddr,
   input wire logic [7:0] ctlWdata,
   output logic [7:0] ctlRdata,
   input wire logic flashRe,
   input wire logic [15:0] flashAddr,
   output logic [7:0] flashRdata,
   input wire logic infoRe,
   input wire logic [6:0] infoAddr,
   output logic [7:0] infoRdata
);
   logic [7:0] ram [256];
   logic [7:0] ctl [256];
   logic [7:0] noise;

   // Stores take writes; unselected outputs churn so stale data is never mistaken for a read.
   always_ff @(posedge clock) begin
      noise <= (noise === 8'hxx) ? 8'h5a : noise + 8'h35;
      if (ramSel && ramWe) begin
         ram[ramAddr] <= ramWdata;
      end
      if (ctlSel && ctlWe) begin
         ctl[ctlAddr] <= ctlWdata;
      end
   end

   // Reads are combinational, valid during the strobe cycle.
   assign ramRdata = ramSel ? ram[ramAddr] : noise;
   assign ctlRdata = ctlSel ? ctl[ctlAddr] : noise;
   assign flashRdata = flashRe ? (flashAddr[7:0] ^ flashAddr[15:8]) : noise;
   assign infoRdata = infoRe ? {1'b1, infoAddr} : noise;
endmodule

// ==== testbench/testbench.sv ====
// Self-checking testbench for the address space decoder.
`timescale 1ns/1ps
module testbench;
   logic clock, rst, rfRd, rfWr, rfRdValid, pmRd, pmWr, pmRdValid, dmRd, dmWr, dmDropped;
   logic ramSel, ramWe, ctlSel, ctlWe, flashRe, flashWe, infoRe;
   logic [11:0] rfAddr;
   logic [15:0] pmAddr, flashAddr;
   logic [7:0] rfWdata, rfRdata, pmWdata, pmRdata, pageSel, ramAddr, ramWdata, ramRdata;
   logic [7:0] ctlAddr, ctlWdata, ctlRdata, flashWdata, flashRdata, infoRdata;
   logic [6:0] infoAddr;
   asd_pkg::asd_region_t pmRegion;
   int err_count = 0;
   int checked = 0;

   asd_address_space_decoder DUT (.clock(clock), .rst(rst), .rfAddr(rfAddr), .rfRd(rfRd),
      .rfWr(rfWr), .rfWdata(rfWdata), .rfRdata(rfRdata), .rfRdValid(rfRdValid),
      .pmAddr(pmAddr), .pmRd(pmRd), .pmWr(pmWr), .pmWdata(pmWdata), .pmRdata(pmRdata),
      .pmRdValid(pmRdValid), .pmRegion(pmRegion), .dmRd(dmRd), .dmWr(dmWr),
      .dmDropped(dmDropped), .ramSel(ramSel), .ramWe(ramWe), .ramAddr(ramAddr),
      .ramWdata(ramWdata), .ramRdata(ramRdata), .ctlSel(ctlSel), .ctlWe(ctlWe),
      .ctlAddr(ctlAddr), .ctlWdata(ctlWdata), .ctlRdata(ctlRdata), .flashRe(flashRe),
      .flashWe(flashWe), .flashAddr(flashAddr), .flashWdata(flashWdata),
      .flashRdata(flashRdata), .infoRe(infoRe), .infoAddr(infoAddr), .infoRdata(infoRdata),
      .pageSel(pageSel));

   asd_mem_model mem (.clock(clock), .ramSel(ramSel), .ramWe(ramWe), .ramAddr(ramAddr),
      .ramWdata(ramWdata), .ramRdata(ramRdata), .ctlSel(ctlSel), .ctlWe(ctlWe),
      .ctlAddr(ctlAddr), .ctlWdata(ctlWdata), .ctlRdata(ctlRdata), .flashRe(flashRe),
      .flashAddr(flashAddr), .flashRdata(flashRdata), .infoRe(infoRe), .infoAddr(infoAddr),
      .infoRdata(infoRdata));

   // ****************************************
   // Clock and shared tasks
   // ****************************************
   // Free-running 100 ns clock.
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] time %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One register file access, driven at falling edges; returns the read data.
   task automatic rf_op(input logic [11:0] a, input logic rd, input logic wr,
                        input logic [7:0] wd, output logic [7:0] q);
      @(negedge clock);
      rfAddr = a; rfRd = rd; rfWr = wr; rfWdata = wd;
      @(negedge clock);
      rfRd = 1'b0; rfWr = 1'b0;
      @(negedge clock);
      chk(16'(rfRdValid), 16'(rd));
      q = rfRdata;
   endtask

   // One program memory access; returns read data and the region seen in the strobe cycle.
   task automatic pm_op(input logic [15:0] a, input logic rd, input logic wr,
                        output logic [7:0] q, output asd_pkg::asd_region_t r);
      @(negedge clock);
      pmAddr = a; pmRd = rd; pmWr = wr; pmWdata = 8'h96;
      @(negedge clock);
      pmRd = 1'b0; pmWr = 1'b0; r = pmRegion;
      @(negedge clock);
      chk(16'(pmRdValid), 16'(rd));
      q = pmRdata;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // RAM, control page and the gap between them; a gap write must not alias onto RAM.
   task automatic t_register_file();
      logic [7:0] q;
      rf_op(12'h000, 1'b0, 1'b1, 8'h3c, q);
      rf_op(12'h0ff, 1'b0, 1'b1, 8'hc3, q);
      rf_op(12'hf10, 1'b0, 1'b1, 8'h69, q);
      rf_op(12'h100, 1'b0, 1'b1, 8'he7, q);
      rf_op(12'heff, 1'b0, 1'b1, 8'h18, q);
      rf_op(12'h000, 1'b1, 1'b1, 8'h55, q); chk(16'(q), 16'h003c);
      rf_op(12'h000, 1'b1, 1'b0, 8'h00, q); chk(16'(q), 16'h003c);
      rf_op(12'h0ff, 1'b1, 1'b0, 8'h00, q); chk(16'(q), 16'h00c3);
      rf_op(12'hf10, 1'b1, 1'b0, 8'h00, q); chk(16'(q), 16'h0069);
      rf_op(12'h100, 1'b1, 1'b0, 8'h00, q); chk(16'(q), 16'(asd_pkg::UNDEF_DATA));
      rf_op(12'heff, 1'b1, 1'b0, 8'h00, q); chk(16'(q), 16'(asd_pkg::UNDEF_DATA));
   endtask

   // Program map: vectors, code, flash edge and the unimplemented space above it.
   task automatic t_program_map();
      logic [15:0] pa [10] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h003d,
                               16'h003e, 16'h1fff, 16'h2000, 16'hfe00};
      asd_pkg::asd_region_t pr [10] = '{asd_pkg::REG_OPTION, asd_pkg::REG_OPTION,
         asd_pkg::REG_RESET_VEC, asd_pkg::REG_RESET_VEC, asd_pkg::REG_INT_VEC,
         asd_pkg::REG_INT_VEC, asd_pkg::REG_CODE, asd_pkg::REG_CODE, asd_pkg::REG_NONE,
         asd_pkg::REG_NONE};
      logic [7:0] q;
      asd_pkg::asd_region_t r;
      pageSel = 8'h40;
      pm_op(16'h2000, 1'b0, 1'b1, q, r); chk(16'(r), 16'(asd_pkg::REG_NONE));
      pm_op(16'h0100, 1'b0, 1'b1, q, r); chk(16'(r), 16'(asd_pkg::REG_CODE));
      for (int i = 0; i < 10; i++) begin
         pm_op(pa[i], 1'b1, 1'b0, q, r);
         chk(16'(r), 16'(pr[i]));
         chk(16'(q), (i < 8) ? 16'(pa[i][7:0] ^ pa[i][15:8]) : 16'h00ff);
      end
   endtask

   // Overlay enabled: option, part name, padding, reserved and calibration bytes; then FE00H read with the overlay disabled.
   task automatic t_info_area();
      logic [15:0] ia [10] = '{16'hfe00, 16'hfe3f, 16'hfe40, 16'hfe46, 16'hfe47, 16'hfe53,
                               16'hfe54, 16'hfe5f, 16'hfe60, 16'hfe80};
      logic [7:0] ie [10] = '{8'h80, 8'hbf, 8'h41, 8'h4f, 8'h46, 8'h46, 8'hff, 8'hff, 8'he0,
                              8'hff};
      logic [7:0] q;
      asd_pkg::asd_region_t r;
      pageSel = 8'h80;
      pm_op(16'hfe00, 1'b0, 1'b1, q, r);
      pm_op(16'hfe00, 1'b1, 1'b1, q, r); chk(16'(q), 16'h0080);
      for (int i = 0; i < 10; i++) begin
         pm_op(ia[i], 1'b1, 1'b0, q, r);
         chk(16'(q), 16'(ie[i]));
      end
      pageSel = 8'h00;
      pm_op(16'hfe00, 1'b1, 1'b0, q, r); chk(16'(q), 16'h00ff);
   endtask

   // Data memory requests are dropped, with a one-cycle notice.
   task automatic t_data_memory();
      for (int i = 0; i < 2; i++) begin
         @(negedge clock);
         dmRd = (i == 0); dmWr = (i == 1);
         @(negedge clock);
         dmRd = 1'b0; dmWr = 1'b0;
         chk(16'(dmDropped), 16'h0001);
         @(negedge clock);
         chk(16'(dmDropped), 16'h0000);
      end
   endtask

   // ****************************************
   // Sequence, watchdog and verdict
   // ****************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Inputs start idle; reset is held for 16 cycles before any request.
   initial begin
      rst = 1'b1; rfAddr = '0; rfRd = 1'b0; rfWr = 1'b0; rfWdata = '0; pmAddr = '0;
      pmRd = 1'b0; pmWr = 1'b0; pmWdata = '0; dmRd = 1'b0; dmWr = 1'b0; pageSel = '0;
      repeat (16) @(negedge clock);
      rst = 1'b0;
      t_register_file();
      t_program_map();
      t_info_area();
      t_data_memory();
      final_report();
   end

   // The tests need well under 200 cycles; 2000 means something hung.
   initial begin
      #200000;
      err_count++;
      final_report();
   end
endmodule

bind asd_address_space_decoder asd_checker_sva #(.RAM_BYTES(RAM_BYTES),
   .FLASH_BYTES(FLASH_BYTES)) chk_u (.clock(clock), .rst(rst), .rfAddr(rfAddr), .rfRd(rfRd),
   .rfWr(rfWr), .rfWdata(rfWdata), .rfRdValid(rfRdValid), .pmAddr(pmAddr), .pmRd(pmRd),
   .pmWr(pmWr), .pmRdata(pmRdata), .pmRdValid(pmRdValid), .pmRegion(pmRegion), .dmRd(dmRd),
   .pmWdata(pmWdata), .flashWdata(flashWdata),
   .dmWr(dmWr), .dmDropped(dmDropped), .ramSel(ramSel), .ramWe(ramWe), .ramAddr(ramAddr),
   .ctlSel(ctlSel), .ctlWe(ctlWe), .ctlAddr(ctlAddr), .ctlWdata(ctlWdata),
   .flashRe(flashRe), .flashWe(flashWe), .flashAddr(flashAddr), .infoRe(infoRe),
   .infoAddr(infoAddr), .pageSel(pageSel));
